// >>> lrr_pkg.sv
// constants and carrier types of the light result readout block
package lrr_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RESULT_STATUS = 8'h94;
  localparam logic [7:0] ADDR_CH0_LOW       = 8'h95;
  localparam logic [7:0] ADDR_CH0_HIGH      = 8'h96;
  localparam logic [7:0] ADDR_CH1_LOW       = 8'h97;
  localparam logic [7:0] ADDR_CH1_HIGH      = 8'h98;
  localparam logic [7:0] ADDR_CH2_LOW       = 8'h99;
  localparam logic [7:0] ADDR_CH2_HIGH      = 8'h9a;
  localparam logic [7:0] ADDR_GAIN_CH01     = 8'h9b;
  localparam logic [7:0] ADDR_GAIN_CH2      = 8'h9c;
  localparam logic [7:0] ADDR_SAT_VALID     = 8'h9d;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int STEP_LSB      = 6;
  localparam int ASAT_CH0_BIT  = 5;
  localparam int SCALE_CH0_BIT = 2;
  localparam int GAIN_HI_LSB   = 4;
  localparam int VALID_BIT     = 6;
  localparam int LOVF_BIT      = 4;
  localparam int FOVF_BIT      = 3;

  // ----------------------------------------------------------------
  // widths, codes, counts and reset values
  // ----------------------------------------------------------------
  localparam int          NUM_CH      = 3;
  localparam int          ACC_W       = 26;
  localparam int          RES_W       = 16;
  localparam logic [3:0]  MAX_SHIFT   = 4'ha;
  localparam int          ITIME_SHIFT = 10;
  localparam logic [15:0] CODE_FMT_OVF = 16'hfffe;
  localparam logic [15:0] CODE_ANA_SAT = 16'hffff;
  localparam logic [7:0]  REG_RESET    = 8'h00;

  // one channel as it leaves the accumulator at the end of a cycle
  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic             analog_sat;
    logic [3:0]       gain;
  } lrr_ch_meas_t;

  // one complete integration cycle, carried across the clock crossing
  typedef struct packed {
    lrr_ch_meas_t [NUM_CH-1:0] ch;
    logic [1:0]                step;
    logic                      flicker_at_max;
  } lrr_cycle_t;

  // one channel as presented to the host
  typedef struct packed {
    logic [RES_W-1:0] data;
    logic             analog_sat;
    logic             unscaled;
    logic [3:0]       gain;
  } lrr_ch_res_t;

  typedef struct packed {
    lrr_ch_res_t [NUM_CH-1:0] ch;
    logic [1:0]               step;
  } lrr_res_set_t;

endpackage

// >>> lrr_readout.sv
// light result readout: cycle capture, clock crossing, windowing and host registers
//
// Behaviour
// - status bits 7:6 give sequencer step of the latched results
// - status bits 5,4,3 flag analog saturation of channels 0,1,2
// - status bits 2,1,0: 0 means multiply by 2^exponent, 1 unscaled
// - results refresh only when the status register is read
// - each 16-bit result spans two bytes, low byte at lower address
// - consecutive low-then-high reads return one coherent result set
// - all three latched results come from the same integration cycle
// - each result is a 16-bit window of a 26-bit accumulator
// - format overflow reads 0xfffe, analog saturation reads 0xffff
// - gain register holds channel 1 code in 7:4, channel 0 in 3:0
// - second gain register holds channel 2 code in 3:0, upper reserved
// - valid flag bit 6 set after a full cycle since enable or status read
// - light overflow bit 4 set when count exceeds format limit or reaches time limit
// - flicker overflow bit 3 set when flicker counter hits maximum
// - bits 2,1,0 flag analog overload of modulators 2,1,0
module lrr_readout
  import lrr_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // measurement side, on its own clock
  input  wire logic       meas_clk,
  input  wire logic       cycle_done,
  input  wire lrr_cycle_t cycle_in,
  // measurement configuration, on mclk
  input  wire logic       light_measure_enable,
  input  wire logic       scale_setting,
  input  wire logic [3:0] result_top_bit_select,
  input  wire logic [7:0] integration_time_setting,
  // host register port
  input  wire logic       reg_rd_en,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_addr,
  output logic      [7:0] reg_rd_data,
  output logic            reg_rd_valid
);

  // ----------------------------------------------------------------
  // measurement clock domain
  // ----------------------------------------------------------------
  logic       meas_rst_q1;
  logic       meas_rst_n;
  logic       req_tgl;
  logic       ack_q1;
  logic       ack_q2;
  logic       ack_tgl;
  lrr_cycle_t hold;
  logic       meas_busy;

  // reset release is brought into the measurement domain
  always_ff @(posedge meas_clk) begin
    meas_rst_q1 <= reset_n;
    meas_rst_n  <= meas_rst_q1;
  end

  always_ff @(posedge meas_clk) begin
    ack_q1 <= ack_tgl;
    ack_q2 <= ack_q1;
  end

  assign meas_busy = req_tgl != ack_q2;

  // a whole cycle is frozen in one register before it crosses, so the three
  // channels can never come from different cycles; a cycle that ends while the
  // previous one is still crossing is dropped rather than mixed in
  always_ff @(posedge meas_clk) begin
    if (!meas_rst_n) begin
      hold    <= '0;
      req_tgl <= 1'b0;
    end else if (cycle_done && !meas_busy) begin
      hold    <= cycle_in;
      req_tgl <= ~req_tgl;
    end
  end

  hold_stable_a: assert property (@(posedge meas_clk) disable iff (!meas_rst_n)
    meas_busy |=> $stable(hold))
    else $error("held cycle changed while crossing");

  // ----------------------------------------------------------------
  // crossing into mclk
  // ----------------------------------------------------------------
  logic       req_q1;
  logic       req_q2;
  logic       req_q3;
  logic       cycle_arrived;
  logic       arrived_q;
  logic       got_cycle;
  lrr_cycle_t fresh;

  always_ff @(posedge mclk) begin
    req_q1 <= req_tgl;
    req_q2 <= req_q1;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      req_q3  <= 1'b0;
      ack_tgl <= 1'b0;
    end else begin
      req_q3  <= req_q2;
      ack_tgl <= req_q2;
    end
  end

  assign cycle_arrived = req_q2 ^ req_q3;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fresh <= '0;
    end else if (cycle_arrived) begin
      fresh <= hold;
    end
  end

  // summary flags are taken one edge after arrival, once fresh holds the new
  // cycle; taking them at arrival would report the previous cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      arrived_q <= 1'b0;
    end else begin
      arrived_q <= cycle_arrived;
    end
  end

  // until a cycle has arrived the status byte must read as its reset value
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      got_cycle <= 1'b0;
    end else if (cycle_arrived) begin
      got_cycle <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // accumulator windowing
  // ----------------------------------------------------------------
  logic [3:0]       scale_exponent;
  logic [ACC_W-1:0] itime_limit;
  logic [8:0]       itime_steps;
  lrr_res_set_t     next_set;
  logic [2:0]       fmt_ovf;
  logic [2:0]       time_ovf;

  // a larger top bit trades resolution for range; the host undoes it
  assign scale_exponent = !scale_setting ? 4'h0 :
                          (result_top_bit_select > MAX_SHIFT) ? MAX_SHIFT :
                          result_top_bit_select;
  assign itime_steps = {1'b0, integration_time_setting} + 9'h001;
  assign itime_limit = ACC_W'({itime_steps, {ITIME_SHIFT{1'b0}}});

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_win
      logic [ACC_W-1:0] acc;
      logic [ACC_W-1:0] shifted;
      lrr_ch_res_t      res;
      assign acc     = fresh.ch[gi].acc;
      assign shifted = acc >> scale_exponent;
      assign fmt_ovf[gi]  = (shifted >> RES_W) != '0;
      assign time_ovf[gi] = acc >= itime_limit;
      // one process per channel writes only its own result word
      always_comb begin
        res.analog_sat = fresh.ch[gi].analog_sat;
        res.gain       = fresh.ch[gi].gain;
        res.unscaled   = got_cycle && (scale_exponent == 4'h0);
        if (fresh.ch[gi].analog_sat) begin
          res.data = CODE_ANA_SAT;
        end else if (fmt_ovf[gi]) begin
          res.data = CODE_FMT_OVF;
        end else begin
          res.data = shifted[RES_W-1:0];
        end
      end
      assign next_set.ch[gi] = res;
    end
  endgenerate

  assign next_set.step = fresh.step;

  // ----------------------------------------------------------------
  // latched result set and status flags
  // ----------------------------------------------------------------
  lrr_res_set_t latched;
  logic         status_read;
  logic         result_valid_flag;
  logic         light_count_overflow;
  logic         flicker_count_overflow;
  logic [2:0]   mod_analog_overload;
  logic         enable_q;

  assign status_read = reg_rd_en && (reg_addr == ADDR_RESULT_STATUS);

  // only a status read moves results into view, so the data bytes read
  // afterwards all belong to the set the status byte described
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      latched <= '0;
    end else if (status_read) begin
      latched <= next_set;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= light_measure_enable;
    end
  end

  // a cycle landing in the same edge as the clearing read still sets the flag
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      result_valid_flag <= 1'b0;
    end else if (cycle_arrived && light_measure_enable) begin
      result_valid_flag <= 1'b1;
    end else if (status_read || (light_measure_enable && !enable_q)) begin
      result_valid_flag <= 1'b0;
    end
  end

  // saturation summary follows the most recent completed cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      light_count_overflow   <= 1'b0;
      flicker_count_overflow <= 1'b0;
      mod_analog_overload    <= 3'h0;
    end else if (arrived_q) begin
      light_count_overflow   <= |(fmt_ovf | time_ovf);
      flicker_count_overflow <= fresh.flicker_at_max;
      mod_analog_overload    <= {fresh.ch[2].analog_sat,
                                 fresh.ch[1].analog_sat,
                                 fresh.ch[0].analog_sat};
    end
  end

  // ----------------------------------------------------------------
  // host read port
  // ----------------------------------------------------------------
  logic [7:0] next_rd_data;
  logic [7:0] status_byte;

  // the status byte answers with the set it is latching in the same edge
  assign status_byte = {next_set.step,
                        next_set.ch[0].analog_sat, next_set.ch[1].analog_sat,
                        next_set.ch[2].analog_sat,
                        next_set.ch[0].unscaled, next_set.ch[1].unscaled,
                        next_set.ch[2].unscaled};

  always_comb begin
    next_rd_data = REG_RESET;
    if (reg_addr == ADDR_RESULT_STATUS) begin
      next_rd_data = status_byte;
    end else if (reg_addr == ADDR_CH0_LOW) begin
      next_rd_data = latched.ch[0].data[7:0];
    end else if (reg_addr == ADDR_CH0_HIGH) begin
      next_rd_data = latched.ch[0].data[15:8];
    end else if (reg_addr == ADDR_CH1_LOW) begin
      next_rd_data = latched.ch[1].data[7:0];
    end else if (reg_addr == ADDR_CH1_HIGH) begin
      next_rd_data = latched.ch[1].data[15:8];
    end else if (reg_addr == ADDR_CH2_LOW) begin
      next_rd_data = latched.ch[2].data[7:0];
    end else if (reg_addr == ADDR_CH2_HIGH) begin
      next_rd_data = latched.ch[2].data[15:8];
    end else if (reg_addr == ADDR_GAIN_CH01) begin
      next_rd_data = {latched.ch[1].gain, latched.ch[0].gain};
    end else if (reg_addr == ADDR_GAIN_CH2) begin
      next_rd_data = {4'h0, latched.ch[2].gain};
    end else if (reg_addr == ADDR_SAT_VALID) begin
      next_rd_data = {1'b0, result_valid_flag, 1'b0, light_count_overflow,
                      flicker_count_overflow, mod_analog_overload};
    end
  end

  // writes reach no storage at all, whatever address they name
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reg_rd_data  <= REG_RESET;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en && !reg_wr_en;
      if (reg_rd_en) begin
        reg_rd_data <= next_rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  step_report_a: assert property (@(posedge mclk) disable iff (!reset_n)
    status_read |=> reg_rd_data[7:STEP_LSB] == latched.step)
    else $error("status step differs from latched step");

  asat_report_a: assert property (@(posedge mclk) disable iff (!reset_n)
    status_read |=> reg_rd_data[ASAT_CH0_BIT] == latched.ch[0].analog_sat)
    else $error("channel 0 analog flag wrong");

  scale_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
    status_read |=> reg_rd_data[SCALE_CH0_BIT] == (latched.ch[0].unscaled))
    else $error("channel 0 scaling flag wrong");

  hold_results_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !status_read |=> $stable(latched))
    else $error("results changed without status read");

  byte_order_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_rd_en && reg_addr == ADDR_CH1_HIGH) |=>
      reg_rd_data == latched.ch[1].data[15:8])
    else $error("channel 1 high byte wrong");

  sat_code_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (status_read && fresh.ch[2].analog_sat) |=> latched.ch[2].data == CODE_ANA_SAT)
    else $error("analog saturation code missing");

  ovf_code_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (status_read && !fresh.ch[0].analog_sat && fmt_ovf[0]) |=>
      latched.ch[0].data == CODE_FMT_OVF)
    else $error("format overflow code missing");

  gain_ch2_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_rd_en && reg_addr == ADDR_GAIN_CH2) |=> reg_rd_data[7:4] == 4'h0)
    else $error("reserved gain bits not zero");

  valid_set_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (cycle_arrived && light_measure_enable) |=> result_valid_flag)
    else $error("valid flag not set after cycle");

  valid_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (status_read && !cycle_arrived) |=> !result_valid_flag)
    else $error("valid flag not cleared by status read");

  flicker_ovf_a: assert property (@(posedge mclk) disable iff (!reset_n)
    cycle_arrived |=> ##1 (flicker_count_overflow == $past(fresh.flicker_at_max)))
    else $error("flicker overflow not reported");

  mod_overload_a: assert property (@(posedge mclk) disable iff (!reset_n)
    cycle_arrived |=> ##1 (mod_analog_overload[0] == $past(fresh.ch[0].analog_sat)))
    else $error("modulator 0 overload not reported");

  light_ovf_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (arrived_q && fresh.ch[0].acc >= itime_limit) |=> light_count_overflow)
    else $error("time limit overflow not reported");

  gain_ch01_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_rd_en && reg_addr == ADDR_GAIN_CH01) |=>
      reg_rd_data == {latched.ch[1].gain, latched.ch[0].gain})
    else $error("channel 0 and 1 gain byte wrong");

  unmapped_zero_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_rd_en && (reg_addr < ADDR_RESULT_STATUS || reg_addr > ADDR_SAT_VALID))
      |=> reg_rd_data == REG_RESET)
    else $error("unmapped read not zero");

endmodule

// >>> lrr_meas_src.sv
// model of the measurement side: hands whole cycles across on its own clock
module lrr_meas_src
  import lrr_pkg::*;
(
  input  wire logic       meas_clk,
  input  wire logic       send_tgl,
  input  wire lrr_cycle_t next_cycle,
  output logic            cycle_done,
  output lrr_cycle_t      cycle_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] tgl_sync = 3'h0;
  lrr_cycle_t last     = '0;
  initial cycle_done = 1'b0;
  initial cycle_in = '1;
  // a toggle from the bench marks a new cycle; outside the pulse the word is scrambled
  always @(posedge meas_clk) begin
    tgl_sync <= {tgl_sync[1:0], send_tgl};
    if (tgl_sync[2] != tgl_sync[1]) begin
      cycle_done <= 1'b1;
      cycle_in   <= next_cycle;
      last       <= next_cycle;
    end else begin
      cycle_done <= 1'b0;
      cycle_in   <= ~last;
    end
  end
endmodule

// >>> tb_light_result_readout.sv
// self-checking bench of the light result readout block
module tb_light_result_readout;
  timeunit 1ns;
  timeprecision 1ps;
  import lrr_pkg::*;
  logic       mclk = 1'b0;
  logic       meas_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       cycle_done;
  lrr_cycle_t cycle_in;
  lrr_cycle_t nxt = '0;
  logic       send_tgl = 1'b0;
  logic       enable = 1'b0;
  logic       scale = 1'b0;
  logic [3:0] top_sel = 4'h0;
  logic [7:0] itime = 8'hff;
  logic       rd_en = 1'b0;
  logic       wr_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] rd_data;
  logic       rd_valid;
  int         n_fail = 0;
  int         checks_done = 0;

  initial forever #50 mclk = ~mclk;
  // phase offset keeps the link clock unrelated to mclk
  initial begin
    #1.7;
    forever #3 meas_clk = ~meas_clk;
  end

  lrr_meas_src src (.meas_clk(meas_clk), .send_tgl(send_tgl), .next_cycle(nxt),
                    .cycle_done(cycle_done), .cycle_in(cycle_in));

  lrr_readout dut (.mclk(mclk), .reset_n(reset_n), .meas_clk(meas_clk),
    .cycle_done(cycle_done), .cycle_in(cycle_in), .light_measure_enable(enable),
    .scale_setting(scale), .result_top_bit_select(top_sel),
    .integration_time_setting(itime), .reg_rd_en(rd_en), .reg_wr_en(wr_en),
    .reg_addr(addr), .reg_rd_data(rd_data), .reg_rd_valid(rd_valid));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // one read: request held across one rising edge, answer taken one cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    addr  = a;
    rd_en = 1'b1;
    @(negedge mclk);
    rd_en = 1'b0;
    chk($sformatf("valid at %h", a), 8'h01, {7'h0, rd_valid});
    chk($sformatf("byte at %h", a), exp, rd_data);
  endtask

  task automatic setch(input int i, input logic [25:0] acc, input logic s,
                       input logic [3:0] g);
    nxt.ch[i] = '{acc, s, g};
  endtask

  // the crossing takes a few cycles of each clock; 30 mclk leaves ample margin
  task automatic send(input logic [1:0] step, input logic fl);
    nxt.step = step;
    nxt.flicker_at_max = fl;
    send_tgl = ~send_tgl;
    repeat (30) @(negedge mclk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int a = 8'h94; a <= 8'h9e; a++) begin
      rd(a[7:0], 8'h00);
    end
    $display("test reset values done");
  endtask

  task automatic t_plain;
    setch(0, 26'h1234, 1'b0, 4'h3);
    setch(1, 26'habcd, 1'b0, 4'h5);
    setch(2, 26'h00ff, 1'b0, 4'h9);
    send(2'd2, 1'b0);
    rd(ADDR_SAT_VALID, 8'h40);
    rd(ADDR_RESULT_STATUS, 8'h87);
    rd(ADDR_CH0_LOW, 8'h34);
    rd(ADDR_CH0_HIGH, 8'h12);
    rd(ADDR_CH1_LOW, 8'hcd);
    rd(ADDR_CH1_HIGH, 8'hab);
    rd(ADDR_CH2_LOW, 8'hff);
    rd(ADDR_CH2_HIGH, 8'h00);
    rd(ADDR_GAIN_CH01, 8'h53);
    rd(ADDR_GAIN_CH2, 8'h09);
    rd(ADDR_SAT_VALID, 8'h00);
    $display("test plain cycle done");
  endtask

  task automatic t_window;
    scale   = 1'b1;
    top_sel = 4'h4;
    setch(0, 26'h0000001, 1'b1, 4'h1);
    setch(1, 26'h3ffffff, 1'b0, 4'h2);
    setch(2, 26'h0012340, 1'b0, 4'hf);
    send(2'd1, 1'b1);
    rd(ADDR_SAT_VALID, 8'h59);
    rd(ADDR_RESULT_STATUS, 8'h60);
    rd(ADDR_CH0_LOW, 8'hff);
    rd(ADDR_CH0_HIGH, 8'hff);
    rd(ADDR_CH1_LOW, 8'hfe);
    rd(ADDR_CH1_HIGH, 8'hff);
    rd(ADDR_CH2_LOW, 8'h34);
    rd(ADDR_CH2_HIGH, 8'h12);
    rd(ADDR_GAIN_CH01, 8'h21);
    rd(ADDR_GAIN_CH2, 8'h0f);
    $display("test window and saturation done");
  endtask

  // a new cycle must stay hidden until the status read; writes change nothing
  task automatic t_hold;
    itime   = 8'h00;
    scale   = 1'b0;
    setch(0, 26'h0000400, 1'b0, 4'h6);
    setch(1, 26'h0000010, 1'b0, 4'h6);
    setch(2, 26'h0000020, 1'b0, 4'h6);
    send(2'd3, 1'b0);
    @(negedge mclk);
    addr  = ADDR_CH0_LOW;
    wr_en = 1'b1;
    @(negedge mclk);
    wr_en = 1'b0;
    rd(ADDR_CH0_LOW, 8'hff);
    rd(ADDR_CH1_LOW, 8'hfe);
    rd(ADDR_SAT_VALID, 8'h50);
    rd(ADDR_RESULT_STATUS, 8'hc7);
    rd(ADDR_CH0_LOW, 8'h00);
    rd(ADDR_CH0_HIGH, 8'h04);
    rd(ADDR_CH2_LOW, 8'h20);
    rd(ADDR_GAIN_CH01, 8'h66);
    $display("test hold until status read done");
  endtask

  // top bit clamp, valid gated by enable, read beside a write, reset in mid-run
  task automatic t_modes;
    enable  = 1'b0;
    scale   = 1'b1;
    top_sel = 4'hf;
    itime   = 8'hff;
    setch(0, 26'h0abcd00, 1'b0, 4'h1);
    setch(2, 26'h1000000, 1'b0, 4'h3);
    send(2'd0, 1'b0);
    rd(ADDR_SAT_VALID, 8'h10);
    rd(ADDR_RESULT_STATUS, 8'h00);
    rd(ADDR_CH0_LOW, 8'hf3);
    rd(ADDR_CH2_HIGH, 8'h40);
    @(negedge mclk);
    addr  = ADDR_CH0_HIGH;
    rd_en = 1'b1;
    wr_en = 1'b1;
    @(negedge mclk);
    rd_en = 1'b0;
    wr_en = 1'b0;
    chk("valid beside write", 8'h00, {7'h0, rd_valid});
    chk("byte beside write", 8'h2a, rd_data);
    enable = 1'b1;
    send(2'd0, 1'b0);
    rd(ADDR_SAT_VALID, 8'h50);
    enable = 1'b0;
    @(negedge mclk);
    enable = 1'b1;
    rd(ADDR_SAT_VALID, 8'h10);
    reset_n = 1'b0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    for (int a = 8'h94; a <= 8'h9d; a++) begin
      rd(a[7:0], 8'h00);
    end
    $display("test modes and mid-run reset done");
  endtask

  initial begin
    #500_000;
    n_fail++;
    $display("watchdog expired before the tests ended");
    tally_and_finish();
  end

  initial begin
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    enable  = 1'b1;
    t_reset();
    t_plain();
    t_window();
    t_hold();
    t_modes();
    tally_and_finish();
  end
endmodule
